// ### rtl/sfrb_top.sv
`timescale 1ns/1ps
`include "sfrb_defines.svh"

module sfrb_top (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    power_up_clear_i,
    input  wire sfrb_pkg::sfrb_bus_req_t bus_i,
    input  wire sfrb_pkg::sfrb_events_t  evt_i,
    input  wire logic                    flash_violation_i,
    input  wire logic                    wdog_interval_mode_i,
    input  wire logic                    gie_i,
    output      logic [7:0]              rdata_o,
    output      sfrb_pkg::sfrb_irq_t     irq_o,
    output      logic                    nmi_req_o,
    output      logic                    async_tx_enable_o,
    output      logic                    async_rx_enable_o
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // each register is a full 8-bit flop; writes mask it to the implemented bits
    logic [7:0] irq_en;
    logic [7:0] flags;
    logic [7:0] mod_en;
    logic [7:0] next_irq_en;
    logic [7:0] next_flags;
    logic [7:0] next_mod_en;
    logic [7:0] next_rdata;
    sfrb_pkg::sfrb_irq_t next_irq;
    logic       next_nmi_req;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    // ----------------------------------------------------------------
    // next register values
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] set_v;
        set_v = 8'h00;
        next_irq_en = irq_en;
        next_flags  = flags;
        next_mod_en = mod_en;
        if (bus_i.wr && hit(bus_i.addr, `SFRB_OFS_IRQ_EN_1)) begin
            next_irq_en = bus_i.wdata & `SFRB_IE1_MASK;
        end
        if (bus_i.wr && hit(bus_i.addr, `SFRB_OFS_FLAGS_1)) begin
            next_flags = bus_i.wdata & `SFRB_INTERRUPT_FLAGS_1_MASK;
        end
        if (bus_i.wr && hit(bus_i.addr, `SFRB_OFS_MOD_EN_1)) begin
            next_mod_en = bus_i.wdata & `SFRB_ME1_MASK;
        end
        // writes to 01h, 03h, 05h fall through with no storage
        set_v[`SFRB_BIT_WDOG] = evt_i.wdog_overflow | evt_i.key_violation;
        set_v[`SFRB_BIT_OSC]  = evt_i.osc_fault;
        set_v[`SFRB_BIT_RST]  = evt_i.pin_reset;
        set_v[`SFRB_BIT_NMI]  = evt_i.pin_nmi;
        set_v[`SFRB_BIT_RX]   = evt_i.serial_rx;
        set_v[`SFRB_BIT_TX]   = evt_i.serial_tx;
        // pin reset clears the watchdog flag; a new watchdog event still wins
        if (evt_i.pin_reset) begin
            next_flags[`SFRB_BIT_WDOG] = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        next_flags = next_flags | set_v;
        // power-up clear: puc bits take defaults, por bits are untouched
        if (power_up_clear_i) begin
            next_irq_en = `SFRB_IE1_PUC;
            next_mod_en = `SFRB_ME1_PUC;
            next_flags  = (next_flags & ~`SFRB_INTERRUPT_FLAGS_1_PUC_MASK) | `SFRB_INTERRUPT_FLAGS_1_PUC;
        end
    end

    // ----------------------------------------------------------------
    // read data and requests
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `SFRB_OFS_IRQ_EN_1: next_rdata = irq_en & `SFRB_IE1_MASK;
                `SFRB_OFS_FLAGS_1:  next_rdata = flags & `SFRB_INTERRUPT_FLAGS_1_MASK;
                `SFRB_OFS_MOD_EN_1: next_rdata = mod_en & `SFRB_ME1_MASK;
                default:            next_rdata = 8'h00;
            endcase
        end
        // watchdog enable is dead in watchdog mode
        next_irq.watchdog = flags[`SFRB_BIT_WDOG] & irq_en[`SFRB_BIT_WDOG]
                          & wdog_interval_mode_i & gie_i;
        next_irq.osc_fault = flags[`SFRB_BIT_OSC] & irq_en[`SFRB_BIT_OSC];
        next_irq.pin_nmi = flags[`SFRB_BIT_NMI] & irq_en[`SFRB_BIT_NMI];
        next_irq.flash_violation = flash_violation_i & irq_en[`SFRB_BIT_ACCV];
        next_irq.serial_rx = flags[`SFRB_BIT_RX] & irq_en[`SFRB_BIT_RX] & gie_i;
        next_irq.serial_tx = flags[`SFRB_BIT_TX] & irq_en[`SFRB_BIT_TX] & gie_i;
        // gie deliberately not in this term: these sources ignore it
        next_nmi_req = next_irq.osc_fault | next_irq.pin_nmi | next_irq.flash_violation;
        if (power_up_clear_i) begin
            next_irq = '0;
            next_nmi_req = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // rst_n_i is the power-on reset: por bits load here only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en   <= `SFRB_IE1_PUC;
            flags    <= `SFRB_INTERRUPT_FLAGS_1_POR;
            mod_en   <= `SFRB_ME1_PUC;
            rdata_o  <= 8'h00;
            irq_o    <= '0;
            nmi_req_o <= 1'b0;
            async_tx_enable_o <= 1'b0;
            async_rx_enable_o <= 1'b0;
        end else begin
            irq_en   <= next_irq_en;
            flags    <= next_flags;
            mod_en   <= next_mod_en;
            rdata_o  <= next_rdata;
            irq_o    <= next_irq;
            nmi_req_o <= next_nmi_req;
            async_tx_enable_o <= next_mod_en[`SFRB_BIT_TX];
            async_rx_enable_o <= next_mod_en[`SFRB_BIT_RX];
        end
    end

endmodule

// ### rtl/sfrb_defines.svh
`ifndef SFRB_DEFINES_SVH
`define SFRB_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SFRB_ADDR_W          4
`define SFRB_OFS_IRQ_EN_1    4'h0
`define SFRB_OFS_IRQ_EN_2    4'h1
`define SFRB_OFS_FLAGS_1     4'h2
`define SFRB_OFS_FLAGS_2     4'h3
`define SFRB_OFS_MOD_EN_1    4'h4
`define SFRB_OFS_MOD_EN_2    4'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFRB_BIT_WDOG        0
`define SFRB_BIT_OSC         1
`define SFRB_BIT_POR         2
`define SFRB_BIT_RST         3
`define SFRB_BIT_NMI         4
`define SFRB_BIT_ACCV        5
`define SFRB_BIT_RX          6
`define SFRB_BIT_TX          7

// ----------------------------------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------------------------------
`define SFRB_IE1_MASK        8'hF3
`define SFRB_INTERRUPT_FLAGS_1_MASK       8'hDF
`define SFRB_ME1_MASK        8'hC0
`define SFRB_IE1_PUC         8'h00
`define SFRB_INTERRUPT_FLAGS_1_PUC_MASK   8'hD2
`define SFRB_INTERRUPT_FLAGS_1_PUC        8'h82
`define SFRB_INTERRUPT_FLAGS_1_POR        8'h86
`define SFRB_ME1_PUC         8'h00

`endif

// ### rtl/sfrb_pkg.sv
package sfrb_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } sfrb_bus_req_t;

    typedef struct packed {
        logic wdog_overflow;
        logic key_violation;
        logic osc_fault;
        logic pin_reset;
        logic pin_nmi;
        logic serial_rx;
        logic serial_tx;
    } sfrb_events_t;

    typedef struct packed {
        logic watchdog;
        logic osc_fault;
        logic pin_nmi;
        logic flash_violation;
        logic serial_rx;
        logic serial_tx;
    } sfrb_irq_t;

endpackage

// ### sim/sfrb_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks of the register bank
// ----------------------------------------
module sfrb_assertions (
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    input wire logic                    power_up_clear_i,
    input wire sfrb_pkg::sfrb_bus_req_t bus_i,
    input wire sfrb_pkg::sfrb_events_t  evt_i,
    input wire logic                    flash_violation_i,
    input wire logic                    wdog_interval_mode_i,
    input wire logic                    gie_i,
    input wire logic [7:0]              rdata_o,
    input wire sfrb_pkg::sfrb_irq_t     irq_o,
    input wire logic                    nmi_req_o,
    input wire logic                    async_tx_enable_o,
    input wire logic                    async_rx_enable_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    rsvd_read_a: assert property (bus_i.rd && (bus_i.addr inside {4'h1, 4'h3, 4'h5}
        || bus_i.addr > 4'h5) |=> rdata_o == 8'h00) else $error("reserved read not zero");
    ie_holes_a: assert property (bus_i.rd && bus_i.addr == 4'h0
        |=> rdata_o[3:2] == 2'b00) else $error("enable holes read back");
    flag_hole_a: assert property (bus_i.rd && bus_i.addr == 4'h2
        |=> rdata_o[5] == 1'b0) else $error("flag bit 5 read back");
    me_holes_a: assert property (bus_i.rd && bus_i.addr == 4'h4
        |=> rdata_o[5:0] == 6'h00) else $error("module enable holes read back");
    puc_irq_a: assert property (power_up_clear_i
        |=> irq_o == '0) else $error("request survives power-up clear");
    gie_mask_a: assert property (!gie_i |=> !irq_o.watchdog && !irq_o.serial_rx
        && !irq_o.serial_tx) else $error("maskable request without global enable");
    wdog_mode_a: assert property (!wdog_interval_mode_i
        |=> !irq_o.watchdog) else $error("watchdog request in watchdog mode");
    nmi_or_a: assert property (nmi_req_o == (irq_o.osc_fault || irq_o.pin_nmi
        || irq_o.flash_violation)) else $error("nmi request mismatch");
    puc_flags_a: assert property (power_up_clear_i ##1 bus_i.rd && bus_i.addr == 4'h2
        |=> rdata_o[7:6] == 2'b10 && !rdata_o[4] && rdata_o[1]) else $error("puc flag values");
endmodule

bind sfrb_top sfrb_assertions sfrb_assertions_i (.*);

// ### sim/sfrb_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// stimulus and read scoreboard
// ----------------------------------------
module sfrb_top_tb;
    logic                    mclk_i = 1'b0, rst_n_i = 1'b0, power_up_clear_i = 1'b0, pend = 1'b0;
    logic                    flash_violation_i = 1'b0, wdog_interval_mode_i = 1'b0, gie_i = 1'b0;
    logic                    nmi_req_o, async_tx_enable_o, async_rx_enable_o;
    logic [7:0]              rdata_o, d, me_v;
    logic [7:0]              expq [$];
    logic [7:0]              m [6] = '{8'hF3, 8'h00, 8'hDF, 8'h00, 8'hC0, 8'h00};
    sfrb_pkg::sfrb_bus_req_t bus_i = '0;
    sfrb_pkg::sfrb_events_t  evt_i = '0;
    sfrb_pkg::sfrb_irq_t     irq_o;
    int                      fail_count = 0, checks = 0, seed = 13;
    sfrb_top sfrb_top_i (.*);
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one bus and event assignment per falling edge, so strobes never glitch
    task automatic step(input logic w, input logic r, input logic [3:0] a,
                        input logic [7:0] v, input logic [6:0] e, input logic [7:0] x);
        @(negedge mclk_i);
        bus_i = {w, r, a, v};
        evt_i = e;
        if (r) expq.push_back(x);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        step(1'b1, 1'b0, a, v, 7'h00, 8'h00);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        step(1'b0, 1'b1, a, 8'h00, 7'h00, x);
    endtask
    task automatic ev(input logic [6:0] e, input int n);
        repeat (n) step(1'b0, 1'b0, 4'h0, 8'h00, e, 8'h00);
    endtask
    task automatic reset_dut();
        rst_n_i = 1'b0;
        repeat (5) @(negedge mclk_i);
        rst_n_i = 1'b1;
    endtask
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk_i) pend <= bus_i.rd;
    always @(negedge mclk_i) begin
        if (pend === 1'b1) cmp(rdata_o, expq.pop_front());
    end
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial begin
        reset_dut();
        for (int a = 0; a < 16; a++) rd(a[3:0], (a == 2) ? 8'h86 : 8'h00);
        repeat (3) begin
            for (int a = 0; a < 6; a++) begin
                d = 8'($random(seed));
                // keep the module enable value: later writes overwrite d
                if (a == 4) me_v = d;
                wr(a[3:0], d);
                rd(a[3:0], d & m[a]);
            end
        end
        ev(7'h00, 2);
        cmp({6'h00, async_tx_enable_o, async_rx_enable_o}, {6'h00, me_v[7:6]});
        flash_violation_i = 1'b1;
        gie_i = 1'b1;
        wdog_interval_mode_i = 1'b1;
        wr(4'h0, 8'hFF);
        wr(4'h2, 8'hFF);
        ev(7'h00, 2);
        cmp({2'b00, irq_o}, 8'h3F);
        gie_i = 1'b0;
        ev(7'h00, 2);
        cmp({2'b00, irq_o}, 8'h1C);
        cmp({7'h00, nmi_req_o}, 8'h01);
        gie_i = 1'b1;
        wdog_interval_mode_i = 1'b0;
        ev(7'h00, 2);
        cmp({2'b00, irq_o}, 8'h1F);
        flash_violation_i = 1'b0;
        ev(7'h00, 2);
        cmp({2'b00, irq_o}, 8'h1B);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h00);
        ev(7'h5F, 1);
        rd(4'h2, 8'hDB);
        ev(7'h08, 1);
        rd(4'h2, 8'hDA);
        ev(7'h20, 1);
        rd(4'h2, 8'hDB);
        power_up_clear_i = 1'b1;
        rd(4'h2, 8'h8B);
        power_up_clear_i = 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        ev(7'h00, 1);
        reset_dut();
        rd(4'h2, 8'h86);
        ev(7'h00, 2);
        complete_run();
    end
endmodule
